//--- hdl/wdf_pkg.sv
// Purpose: Shared constants and carriers for the waveform dead-time extension
// Assumes: Byte-wide register port, one clock
// Notes:   Offsets are byte addresses of the plain register port
package wdf_pkg;
    localparam int          WDF_AW           = 4;
    localparam int          WDF_DW           = 8;
    localparam int          WDF_NCH          = 4;
    localparam int          WDF_NEV          = 8;
    localparam logic [3:0]  WDF_OFF_CTRL     = 4'h0;
    localparam logic [3:0]  WDF_OFF_MASK     = 4'h2;
    localparam logic [3:0]  WDF_OFF_FCTRL    = 4'h3;
    localparam logic [3:0]  WDF_OFF_STATUS   = 4'h4;
    localparam logic [3:0]  WDF_OFF_BOTH     = 4'h6;
    localparam logic [3:0]  WDF_OFF_BOTHBUF  = 4'h7;
    localparam logic [3:0]  WDF_OFF_LS       = 4'h8;
    localparam logic [3:0]  WDF_OFF_HS       = 4'h9;
    localparam logic [3:0]  WDF_OFF_LSBUF    = 4'ha;
    localparam logic [3:0]  WDF_OFF_HSBUF    = 4'hb;
    localparam logic [3:0]  WDF_OFF_OVR      = 4'hc;
    localparam logic [7:0]  WDF_CTRL_MASK    = 8'h3f;
    localparam logic [7:0]  WDF_FCTRL_MASK   = 8'h17;
    localparam logic [7:0]  WDF_ZERO8        = 8'h00;
    localparam logic [1:0]  WDF_ACT_NONE     = 2'h0;
    localparam logic [1:0]  WDF_ACT_TRISTATE = 2'h3;
    localparam int          WDF_BIT_PGM      = 5;
    localparam int          WDF_BIT_COMMON_CHANNEL_MODE_BIT     = 4;
    localparam int          WDF_BIT_DBD      = 4;
    localparam int          WDF_BIT_MODE     = 2;
    localparam int          WDF_BIT_FDF      = 2;
    localparam int          WDF_BIT_HSV      = 1;
    localparam int          WDF_BIT_LSV      = 0;

    typedef struct packed {
        logic [WDF_AW-1:0] addr;
        logic [WDF_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } wdf_bus_t;

    typedef struct packed {
        logic [WDF_DW-1:0] out_val;
        logic [WDF_DW-1:0] out_ovr;
        logic [WDF_DW-1:0] dir_clr;
    } wdf_port_t;
endpackage

//--- hdl/wdf_top.sv
// Purpose: Dead-time insertion, pattern mode and fault protection for a
//          four-channel timer, driving an eight-pin port
// Assumes: Timer waveforms, update and lock come from the same clock; events
//          and debug break arrive from pins and are synchronised here
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module wdf_top
    import wdf_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Register port
    input  wire wdf_pkg::wdf_bus_t     bus,
    output logic [wdf_pkg::WDF_DW-1:0] rdata,
    // Timer side
    input  wire logic [3:0]            wave_in,
    input  wire logic                  timer_update,
    input  wire logic                  timer_lock_commit_flag,
    // Fault sources
    input  wire logic [7:0]            event_in,
    input  wire logic                  debug_break,
    // Port side
    output wdf_pkg::wdf_port_t         port
);
    import wdf_pkg::*;
    // One clock domain, so every check shares this clock and reset
    default clocking wdf_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    typedef enum logic {WDF_RUN, WDF_FAULT} wdf_state_t;

    logic [7:0]  ctrl_r, mask_r, fctrl_r, ls_r, hs_r, lsbuf_r, hsbuf_r, ovr_r;
    logic        fdf_r, lsv_r, hsv_r;
    logic [7:0]  ev_s1_r, ev_s2_r, ev_s3_r;
    logic        dbg_s1_r, dbg_s2_r, dbg_s3_r;
    logic [7:0]  ev_r;
    logic        dbg_r;
    wdf_state_t  state_r;
    logic [3:0]  wave_d_r;
    logic [7:0]  cnt_r [WDF_NCH];
    logic [7:0]  out_nxt;

    wire         prot_en  = fctrl_r[1:0] == WDF_ACT_TRISTATE;
    wire         dbg_flt  = dbg_r & ~fctrl_r[WDF_BIT_DBD];
    wire         fault_in = prot_en & ((|(ev_r & mask_r)) | dbg_flt);
    wire         commit   = timer_update & ~timer_lock_commit_flag;

    function automatic logic wr_at(input logic [3:0] off);
        wr_at = bus.wr && bus.addr == off;
    endfunction

    // Three stages; a change counts once stages two and three agree
    // Limitation: the sync stages add to the fault reaction time
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_s1_r  <= WDF_ZERO8;
            ev_s2_r  <= WDF_ZERO8;
            ev_s3_r  <= WDF_ZERO8;
            ev_r     <= WDF_ZERO8;
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
            dbg_s3_r <= 1'b0;
            dbg_r    <= 1'b0;
        end
        else
        begin
            ev_s1_r  <= event_in;
            ev_s2_r  <= ev_s1_r;
            ev_s3_r  <= ev_s2_r;
            dbg_s1_r <= debug_break;
            dbg_s2_r <= dbg_s1_r;
            dbg_s3_r <= dbg_s2_r;
            for (int i = 0; i < WDF_NEV; i++)
            begin
                if (ev_s2_r[i] == ev_s3_r[i])
                    ev_r[i] <= ev_s3_r[i];
            end
            if (dbg_s2_r == dbg_s3_r)
                dbg_r <= dbg_s3_r;
        end
    end

    // Control registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r  <= WDF_ZERO8;
            mask_r  <= WDF_ZERO8;
            fctrl_r <= WDF_ZERO8;
            ovr_r   <= WDF_ZERO8;
        end
        else
        begin
            if (wr_at(WDF_OFF_CTRL))
                ctrl_r <= bus.wdata & WDF_CTRL_MASK;
            if (wr_at(WDF_OFF_MASK))
                mask_r <= bus.wdata;
            if (wr_at(WDF_OFF_FCTRL))
                fctrl_r <= bus.wdata & WDF_FCTRL_MASK;
            if (wr_at(WDF_OFF_OVR) && !fdf_r)
                ovr_r <= bus.wdata;
        end
    end

    // Fault flag: set wins over a write-one clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fdf_r <= 1'b0;
        else if (fault_in)
            fdf_r <= 1'b1;
        else if (wr_at(WDF_OFF_STATUS) && bus.wdata[WDF_BIT_FDF])
            fdf_r <= 1'b0;
    end

    // Gap values and their buffers; a direct write beats a commit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ls_r    <= WDF_ZERO8;
            hs_r    <= WDF_ZERO8;
            lsbuf_r <= WDF_ZERO8;
            hsbuf_r <= WDF_ZERO8;
            lsv_r   <= 1'b0;
            hsv_r   <= 1'b0;
        end
        else
        begin
            if (commit && lsv_r)
                ls_r <= lsbuf_r;
            if (commit && hsv_r)
                hs_r <= hsbuf_r;
            if (wr_at(WDF_OFF_BOTH) || wr_at(WDF_OFF_LS))
                ls_r <= bus.wdata;
            if (wr_at(WDF_OFF_BOTH) || wr_at(WDF_OFF_HS))
                hs_r <= bus.wdata;
            if (commit)
            begin
                lsv_r <= 1'b0;
                hsv_r <= 1'b0;
            end
            if (wr_at(WDF_OFF_STATUS))
            begin
                if (bus.wdata[WDF_BIT_LSV])
                    lsv_r <= 1'b0;
                if (bus.wdata[WDF_BIT_HSV])
                    hsv_r <= 1'b0;
            end
            if (wr_at(WDF_OFF_BOTHBUF) || wr_at(WDF_OFF_LSBUF))
            begin
                lsbuf_r <= bus.wdata;
                lsv_r   <= 1'b1;
            end
            if (wr_at(WDF_OFF_BOTHBUF) || wr_at(WDF_OFF_HSBUF))
            begin
                hsbuf_r <= bus.wdata;
                hsv_r   <= 1'b1;
            end
        end
    end

    // Fault state machine
    // With protection on, restart waits for an update so the outputs resume in step
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= WDF_RUN;
        else
        begin
            case (state_r)
                WDF_RUN:
                    if (fault_in)
                        state_r <= WDF_FAULT;
                WDF_FAULT:
                    if (!prot_en)
                        state_r <= WDF_RUN;
                    else if (!fault_in && timer_update &&
                             (fctrl_r[WDF_BIT_MODE] || !fdf_r))
                        state_r <= WDF_RUN;
                default:
                    state_r <= WDF_RUN;
            endcase
        end
    end

    // Gap counters; common mode picks channel A for every generator
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_d_r <= 4'h0;
            for (int c = 0; c < WDF_NCH; c++)
                cnt_r[c] <= WDF_ZERO8;
        end
        else
        begin
            for (int c = 0; c < WDF_NCH; c++)
            begin
                logic w;
                w = ctrl_r[WDF_BIT_COMMON_CHANNEL_MODE_BIT] ? wave_in[0] : wave_in[c];
                wave_d_r[c] <= w;
                if (w && !wave_d_r[c])
                    cnt_r[c] <= ls_r;
                else if (!w && wave_d_r[c])
                    cnt_r[c] <= hs_r;
                else if (cnt_r[c] != WDF_ZERO8)
                    cnt_r[c] <= cnt_r[c] - 8'h01;
            end
        end
    end

    // Pin pair per channel: even low side, odd high side
    always_comb
    begin
        out_nxt = WDF_ZERO8;
        for (int c = 0; c < WDF_NCH; c++)
        begin
            logic w;
            w = ctrl_r[WDF_BIT_COMMON_CHANNEL_MODE_BIT] ? wave_in[0] : wave_in[c];
            if (!ctrl_r[c])
                out_nxt[2*c] = w;
            else if (cnt_r[c] == WDF_ZERO8 && w == wave_d_r[c])
            begin
                out_nxt[2*c]   = w;
                out_nxt[2*c+1] = ~w;
            end
        end
        if (ctrl_r[WDF_BIT_PGM])
            out_nxt = ls_r;
    end

    // Port outputs registered; fault direction clear in one edge after sync
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port  <= '0;
            rdata <= WDF_ZERO8;
        end
        else
        begin
            port.out_val <= out_nxt;
            port.out_ovr <= ctrl_r[WDF_BIT_PGM] ? (ovr_r & hs_r) : ovr_r;
            for (int c = 0; c < WDF_NCH; c++)
            begin
                logic hit;
                hit = ctrl_r[c] && (fault_in || state_r == WDF_FAULT);
                port.dir_clr[2*c]   <= hit;
                port.dir_clr[2*c+1] <= hit;
            end
            // Read data stand one cycle, zero otherwise
            rdata <= WDF_ZERO8;
            if (bus.rd)
            begin
                if (bus.addr == WDF_OFF_CTRL)
                    rdata <= ctrl_r;
                else if (bus.addr == WDF_OFF_MASK)
                    rdata <= mask_r;
                else if (bus.addr == WDF_OFF_FCTRL)
                    rdata <= fctrl_r;
                else if (bus.addr == WDF_OFF_STATUS)
                    rdata <= {5'h00, fdf_r, hsv_r, lsv_r};
                else if (bus.addr == WDF_OFF_BOTH || bus.addr == WDF_OFF_LS)
                    rdata <= ls_r;
                else if (bus.addr == WDF_OFF_BOTHBUF ||
                         bus.addr == WDF_OFF_LSBUF)
                    rdata <= lsbuf_r;
                else if (bus.addr == WDF_OFF_HS)
                    rdata <= hs_r;
                else if (bus.addr == WDF_OFF_HSBUF)
                    rdata <= hsbuf_r;
                else if (bus.addr == WDF_OFF_OVR)
                    rdata <= ovr_r;
                else
                    rdata <= WDF_ZERO8;
            end
        end
    end


    // Self-checks on state and outputs that the block drives
    chk_fault_sets_flag: assert property (
        fault_in |=> fdf_r)
        else $error("fault did not set flag");
    chk_flag_clear: assert property (
        !fault_in && wr_at(WDF_OFF_STATUS) && bus.wdata[WDF_BIT_FDF]
        |=> !fdf_r)
        else $error("flag not cleared by write one");
    chk_ovr_locked: assert property (
        fdf_r && wr_at(WDF_OFF_OVR) |=> $stable(ovr_r))
        else $error("override changed under fault");
    chk_ovr_copy: assert property (
        !ctrl_r[WDF_BIT_PGM] |=> port.out_ovr == $past(ovr_r))
        else $error("override enables not passed through");
    chk_both_write: assert property (
        wr_at(WDF_OFF_BOTH) |=> ls_r == hs_r && ls_r == $past(bus.wdata))
        else $error("both-side write mismatch");
    chk_commit_copy: assert property (
        commit && lsv_r && !wr_at(WDF_OFF_BOTH) && !wr_at(WDF_OFF_LS)
        |=> ls_r == $past(lsbuf_r))
        else $error("buffer not committed");
    chk_lock_holds: assert property (
        timer_lock_commit_flag && !bus.wr |=> $stable(ls_r) && $stable(hs_r))
        else $error("commit under lock");
    chk_dir_fast: assert property (
        fault_in && ctrl_r[0] ##1 ctrl_r[0] |-> port.dir_clr[0])
        else $error("fault action late");
    chk_restore_dir: assert property (
        state_r == WDF_RUN && !fault_in |=> port.dir_clr == WDF_ZERO8)
        else $error("direction not restored");
    chk_gap_off: assert property (
        ctrl_r[0] && !ctrl_r[WDF_BIT_PGM] && cnt_r[0] != WDF_ZERO8
        |=> port.out_val[1:0] == 2'b00)
        else $error("output on during gap");
    chk_rise_reload: assert property (
        wave_in[0] && !wave_d_r[0] |=> cnt_r[0] == $past(ls_r))
        else $error("rising edge did not load low side");
    chk_fall_reload: assert property (
        !wave_in[0] && wave_d_r[0] |=> cnt_r[0] == $past(hs_r))
        else $error("falling edge did not load high side");
    chk_common_mode: assert property (
        ctrl_r[WDF_BIT_COMMON_CHANNEL_MODE_BIT] |=> wave_d_r == {WDF_NCH{$past(wave_in[0])}})
        else $error("common mode not applied");
    chk_pattern_out: assert property (
        ctrl_r[WDF_BIT_PGM] |=> port.out_val == $past(ls_r))
        else $error("pattern not taken from gap register");
    chk_latched_hold: assert property (
        state_r == WDF_FAULT && prot_en && fdf_r && !fctrl_r[WDF_BIT_MODE]
        |=> state_r == WDF_FAULT)
        else $error("latched fault left early");
    chk_no_act: assert property (
        !prot_en |=> state_r == WDF_RUN)
        else $error("fault state held while disabled");
    cov_fault: cover property (
        state_r == WDF_RUN ##1 state_r == WDF_FAULT
        ##[1:300] state_r == WDF_RUN);
    cov_cycle_restart: cover property (
        fctrl_r[WDF_BIT_MODE] && fdf_r && state_r == WDF_FAULT
        ##1 state_r == WDF_RUN);
    cov_commit: cover property (commit && lsv_r);
    cov_pattern: cover property (ctrl_r[WDF_BIT_PGM] && |ovr_r);
    cov_common: cover property (ctrl_r[WDF_BIT_COMMON_CHANNEL_MODE_BIT] && |ctrl_r[3:0]);
endmodule

//--- testbench/wdf_gate_model.sv
// Purpose: Gate driver pairs hanging on the eight port pins
// Assumes: Gate inputs carry pull-downs, so a tristated pin reads low
// Notes:   Counts cycles in which both gates of one pair are on
`timescale 1ns/100ps
module wdf_gate_model
    import wdf_pkg::*;
(
    // Clock
    input  wire logic               clock,
    // Port from the block
    input  wire wdf_pkg::wdf_port_t port,
    // Observed levels
    output logic [7:0]              pin_level,
    output int                      shoot_thru
);
    int cnt = 0;

    // Released pin falls to the pull-down, never keeps the last drive
    assign pin_level = port.out_val & ~port.dir_clr;
    assign shoot_thru = cnt;

    // Both gates on is a short through the bridge
    always @(posedge clock)
        for (int c = 0; c < 4; c++)
            if (pin_level[2*c] && pin_level[2*c+1])
                cnt++;
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the dead-time and fault extension
// Assumes: Register master as in the hand-over contract
// Notes:   Table rows first, then hand-written cases
`timescale 1ns/100ps
module tb_top;
    import wdf_pkg::*;
    typedef struct packed {logic [3:0] a; logic [7:0] d, e;} wdf_row_t;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    wdf_bus_t   bus = '0;
    logic [7:0] rdata;
    logic [3:0] wave_in = 4'h0;
    logic       timer_update = 1'b0;
    logic       lock = 1'b0;
    logic [7:0] event_in = 8'h00;
    logic       debug_break = 1'b0;
    wdf_port_t  port;
    logic [7:0] pin_level;
    int         shoot_thru;
    int         failures = 0;
    int         n_tests = 0;
    int         k;
    logic [7:0] rd_v;
    wdf_row_t   rows [9] = '{'{4'h0, 8'hff, 8'h3f}, '{4'h1, 8'hff, 8'h00},
        '{4'h2, 8'ha5, 8'ha5}, '{4'h3, 8'hff, 8'h17}, '{4'h5, 8'hff, 8'h00},
        '{4'h8, 8'h12, 8'h12}, '{4'h9, 8'h34, 8'h34}, '{4'hd, 8'hff, 8'h00},
        '{4'hc, 8'h5a, 8'h5a}};

    wdf_top wdf_top_i (.clock(clock), .rst_n(rst_n), .bus(bus),
        .rdata(rdata), .wave_in(wave_in), .timer_update(timer_update),
        .timer_lock_commit_flag(lock), .event_in(event_in),
        .debug_break(debug_break), .port(port));
    wdf_gate_model wdf_gate_model_i (.clock(clock), .port(port),
        .pin_level(pin_level), .shoot_thru(shoot_thru));

    always #4 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock) bus <= {a, d, 2'b10};
        @(posedge clock) bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock) bus <= {a, 8'h00, 2'b01};
        @(posedge clock) bus <= '0;
        #1 rd_v = rdata;
        chk(rd_v, e);
    endtask

    task automatic upd;
        @(posedge clock) timer_update <= 1'b1;
        @(posedge clock) timer_update <= 1'b0;
        tick(2);
        #1;
    endtask

    // A count of n holds both pins low n+1 edges, seen one edge later
    task automatic dt_edge(input logic v, input logic [7:0] n_gap);
        @(posedge clock) wave_in[0] <= v;
        tick(2);
        #1 chk(port.out_val & 8'h03, 8'h00);
        tick(1);
        #1 chk(port.out_val & 8'h03, 8'h00);
        k = 0;
        while (port.out_val[1:0] == 2'b00 && k < 8)
        begin
            tick(1);
            #1 k++;
        end
        chk(port.out_val & 8'h03, v ? 8'h01 : 8'h02);
        chk(k[7:0], n_gap);
    endtask

    // Three sync flops, the filter flop and one edge; a slow design runs out the bound
    task automatic wait_fault;
        k = 0;
        while (port.dir_clr == 8'h00 && k < 6)
        begin
            tick(1);
            #1 k++;
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        tick(20000);
        failures++;
        $display("watchdog expired");
        give_verdict;
    end

    initial
    begin
        tick(5);
        rst_n <= 1'b1;
        for (k = 0; k < 9; k++)
            if (rows[k].a != 4'h3 && rows[k].a != 4'hc)
                rdc(rows[k].a, 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        wr(WDF_OFF_CTRL, 8'h00);
        wr(WDF_OFF_FCTRL, 8'h00);
        wr(WDF_OFF_OVR, 8'h00);
        $display("register table done");
        wr(WDF_OFF_BOTH, 8'h07);
        rdc(WDF_OFF_LS, 8'h07);
        rdc(WDF_OFF_HS, 8'h07);
        wr(WDF_OFF_BOTHBUF, 8'h03);
        rdc(WDF_OFF_STATUS, 8'h03);
        @(posedge clock) lock <= 1'b1;
        upd;
        rdc(WDF_OFF_LS, 8'h07);
        @(posedge clock) lock <= 1'b0;
        upd;
        rdc(WDF_OFF_STATUS, 8'h00);
        rdc(WDF_OFF_LS, 8'h03);
        rdc(WDF_OFF_HS, 8'h03);
        wr(WDF_OFF_LSBUF, 8'h09);
        rdc(WDF_OFF_LSBUF, 8'h09);
        wr(WDF_OFF_STATUS, 8'h03);
        upd;
        rdc(WDF_OFF_LS, 8'h03);
        wr(WDF_OFF_HSBUF, 8'h04);
        rdc(WDF_OFF_HSBUF, 8'h04);
        rdc(WDF_OFF_STATUS, 8'h02);
        upd;
        rdc(WDF_OFF_HS, 8'h04);
        rdc(WDF_OFF_LS, 8'h03);
        $display("buffer commit done");
        wr(WDF_OFF_CTRL, 8'h01);
        tick(8);
        dt_edge(1'b1, 8'h02);
        dt_edge(1'b0, 8'h03);
        wr(WDF_OFF_CTRL, 8'h13);
        @(posedge clock) wave_in <= 4'he;
        tick(10);
        #1 chk(port.out_val & 8'h0f, 8'h0a);
        @(posedge clock) wave_in <= 4'h0;
        wr(WDF_OFF_LS, 8'h5a);
        wr(WDF_OFF_HS, 8'hf0);
        wr(WDF_OFF_OVR, 8'h3c);
        wr(WDF_OFF_CTRL, 8'h20);
        upd;
        chk(port.out_val, 8'h5a);
        chk(port.out_ovr, 8'h30);
        wr(WDF_OFF_CTRL, 8'h03);
        wr(WDF_OFF_OVR, 8'h00);
        $display("waveform paths done");
        wr(WDF_OFF_MASK, 8'h04);
        wr(WDF_OFF_FCTRL, 8'h03);
        @(posedge clock) event_in <= 8'h01;
        tick(8);
        #1 chk(port.dir_clr, 8'h00);
        @(posedge clock) event_in <= 8'h04;
        wait_fault;
        chk(port.dir_clr, 8'h0f);
        rdc(WDF_OFF_STATUS, 8'h04);
        // Flag still set, so this write must bounce
        wr(WDF_OFF_OVR, 8'hff);
        rdc(WDF_OFF_OVR, 8'h00);
        @(posedge clock) event_in <= 8'h00;
        tick(5);
        upd;
        chk(port.dir_clr, 8'h0f);
        wr(WDF_OFF_STATUS, 8'h04);
        upd;
        chk(port.dir_clr, 8'h00);
        wr(WDF_OFF_FCTRL, 8'h07);
        @(posedge clock) event_in <= 8'h04;
        wait_fault;
        @(posedge clock) event_in <= 8'h00;
        tick(6);
        #1 chk(port.dir_clr, 8'h0f);
        upd;
        chk(port.dir_clr, 8'h00);
        rdc(WDF_OFF_STATUS, 8'h04);
        wr(WDF_OFF_STATUS, 8'h04);
        @(posedge clock) debug_break <= 1'b1;
        wait_fault;
        chk(port.dir_clr, 8'h0f);
        @(posedge clock) debug_break <= 1'b0;
        tick(6);
        upd;
        chk(port.dir_clr, 8'h00);
        wr(WDF_OFF_FCTRL, 8'h17);
        @(posedge clock) debug_break <= 1'b1;
        tick(8);
        #1 chk(port.dir_clr, 8'h00);
        @(posedge clock) debug_break <= 1'b0;
        wr(WDF_OFF_FCTRL, 8'h05);
        @(posedge clock) event_in <= 8'h04;
        tick(8);
        #1 chk(port.dir_clr, 8'h00);
        @(posedge clock) event_in <= 8'h00;
        chk(shoot_thru[7:0], 8'h00);
        $display("fault handling done");
        // Reset in mid-fault: outputs and settings must fall back at once
        wr(WDF_OFF_FCTRL, 8'h03);
        @(posedge clock) event_in <= 8'h04;
        wait_fault;
        chk(port.dir_clr, 8'h0f);
        @(posedge clock) rst_n <= 1'b0;
        tick(2);
        #1 chk(port.dir_clr, 8'h00);
        @(posedge clock) rst_n <= 1'b1;
        rdc(WDF_OFF_STATUS, 8'h00);
        rdc(WDF_OFF_FCTRL, 8'h00);
        tick(8);
        #1 chk(port.dir_clr, 8'h00);
        @(posedge clock) event_in <= 8'h00;
        $display("reset case done");
        give_verdict;
    end
endmodule
